// ==== include/sgx_regs.svh ====
// Register offsets, reset values and timing counts for the GPIO expander
`ifndef SGX_REGS_SVH
`define SGX_REGS_SVH
`define SGX_SLAVE_ADDR_HI 6'h12
`define SGX_OFF_DIR0      8'h00
`define SGX_OFF_TYPE0     8'h04
`define SGX_OFF_DATA0     8'h08
`define SGX_OFF_MASK0     8'h0C
`define SGX_OFF_ISO       8'h0E
`define SGX_OFF_CHG       8'h0F
`define SGX_RST_DIR       8'h00
`define SGX_RST_TYPE      8'h00
`define SGX_RST_DATA      8'h00
`define SGX_RST_MASK      8'h00
`define SGX_RST_ISO       2'h0
`define SGX_ISO_LSB       0
`define SGX_ISO_MSB       1
`define SGX_TIMEOUT_MS    25
`define SGX_CLK_MHZ       250
`endif

// ==== include/sgx_pkg.sv ====
// Types shared by the GPIO expander
package sgx_pkg;
   typedef enum logic [3:0] {
      SGX_IDLE, SGX_ADDR, SGX_ADDR_ACK, SGX_REG, SGX_REG_ACK,
      SGX_WDATA, SGX_WDATA_ACK, SGX_RDATA, SGX_RDATA_ACK, SGX_WAIT
   } sgx_state_t;
endpackage : sgx_pkg

// ==== core/sgx_expander.sv ====
// SMBus-hosted 32-pin GPIO expander with two-branch isolation switch
`include "sgx_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module sgx_expander
   import sgx_pkg::*;
#(
   parameter int         NUM_BANKS   = 4,
   parameter int         TIMEOUT_CYC = `SGX_TIMEOUT_MS * `SGX_CLK_MHZ * 1000
)(
   input  wire logic                   ref_clk_i,
   input  wire logic                   rst_i,
   input  wire logic                   addr_sel_i,
   input  wire logic                   main_serial_clk_i,
   output logic                        main_serial_clk_oe_o,
   input  wire logic                   main_serial_data_i,
   output logic                        main_serial_data_oe_o,
   input  wire logic                   branch1_clk_i,
   output logic                        branch1_clk_oe_o,
   input  wire logic                   branch1_data_i,
   output logic                        branch1_data_oe_o,
   input  wire logic                   branch2_clk_i,
   output logic                        branch2_clk_oe_o,
   input  wire logic                   branch2_data_i,
   output logic                        branch2_data_oe_o,
   input  wire logic [NUM_BANKS*8-1:0] gpio_pins_i,
   output logic      [NUM_BANKS*8-1:0] gpio_pins_o,
   output logic      [NUM_BANKS*8-1:0] gpio_pins_oe_o,
   output logic                        gpio_change_irq_n_o,
   output logic                        gpio_change_irq_n_oe_o
);
   localparam int NB = NUM_BANKS;
   localparam int NP = NUM_BANKS * 8;

   logic [7:0]    dir        [NB];
   logic [7:0]    drv_type   [NB];
   logic [7:0]    out_level  [NB];
   logic [7:0]    evt_mask   [NB];
   logic [7:0]    in_level   [NB];
   logic [7:0]    next_dir   [NB];
   logic [7:0]    next_type  [NB];
   logic [7:0]    next_out   [NB];
   logic [7:0]    next_mask  [NB];
   logic [7:0]    next_in    [NB];
   logic [NB-1:0] chg;
   logic [NB-1:0] next_chg;
   logic [1:0]    iso_sel;
   logic [1:0]    next_iso;
   logic [1:0]    iso_pend;
   logic [1:0]    next_iso_pend;
   logic          iso_apply;
   logic          next_iso_apply;
   logic [NP-1:0] sync1;
   logic [NP-1:0] sync2;
   logic [NP-1:0] pin_prev;

   // Bus sampling, own data drive on the main data pin and on the data pin of each joined branch
   logic       scl_q;
   logic       sda_q;
   logic       scl_d;
   logic       sda_d;
   logic       start_det;
   logic       stop_det;
   logic       scl_rise;
   logic       scl_fall;
   sgx_state_t state;
   sgx_state_t next_state;
   logic [3:0] bitcnt;
   logic [3:0] next_bitcnt;
   logic [7:0] shreg;
   logic [7:0] next_shreg;
   logic [7:0] reg_addr;
   logic [7:0] next_reg_addr;
   logic       is_read;
   logic       next_is_read;
   logic       have_reg;
   logic       next_have_reg;
   logic       sda_drive;
   logic       next_sda_drive;
   logic [1:0] warm;
   logic [1:0] next_warm;
   logic [31:0] tmo;
   logic [31:0] next_tmo;
   logic       wr_stb;
   logic       rd_stb;
   logic [7:0] rd_data;

   // Register decode shared by read and write paths
   function automatic logic reg_valid(input logic [7:0] a);
      reg_valid = (a < 8'(4 * NB)) || (a == `SGX_OFF_ISO)
                  || (a == `SGX_OFF_CHG);
   endfunction : reg_valid

   function automatic logic [7:0] read_reg(input logic [7:0] a,
                                           input logic [7:0] d_dir[NB],
                                           input logic [7:0] d_typ[NB],
                                           input logic [7:0] d_dat[NB],
                                           input logic [7:0] d_msk[NB],
                                           input logic [NB-1:0] c,
                                           input logic [1:0] iso);
      logic [1:0] b;
      b = a[1:0];
      read_reg = 8'h00;
      if (a == `SGX_OFF_ISO)
         read_reg = {6'h00, iso};
      else if (a == `SGX_OFF_CHG)
         read_reg = 8'(c);
      else if (a[7:2] == `SGX_OFF_DIR0 >> 2)
         read_reg = d_dir[b];
      else if (a[7:2] == `SGX_OFF_TYPE0 >> 2)
         read_reg = d_typ[b];
      else if (a[7:2] == `SGX_OFF_DATA0 >> 2)
         read_reg = d_dat[b];
      else if (a[7:2] == `SGX_OFF_MASK0 >> 2)
         read_reg = d_msk[b];
   endfunction : read_reg

   logic [7:0] data_view [NB];
   always_comb
   begin
      for (int k = 0; k < NB; k++)
         data_view[k] = (dir[k] & out_level[k]) | (~dir[k] & in_level[k]);
   end
   assign rd_data = read_reg(reg_addr, dir, drv_type, data_view, evt_mask,
                             chg, iso_sel);

   always_comb
   begin
      start_det = scl_q && scl_d && sda_d && !sda_q;
      stop_det  = scl_q && scl_d && !sda_d && sda_q;
      scl_rise  = scl_q && !scl_d;
      scl_fall  = !scl_q && scl_d;
   end

   always_comb
   begin
      next_state       = state;
      next_bitcnt      = bitcnt;
      next_shreg       = shreg;
      next_reg_addr    = reg_addr;
      next_is_read     = is_read;
      next_have_reg    = have_reg;
      next_sda_drive   = sda_drive;
      next_tmo         = (scl_q || state == SGX_IDLE) ? 32'h0 : tmo + 32'h1;
      wr_stb           = 1'b0;
      rd_stb           = 1'b0;
      if (start_det)
      begin
         next_state       = SGX_ADDR;
         next_bitcnt      = 4'h0;
         next_sda_drive   = 1'b0;
      end
      else if (stop_det || tmo >= 32'(TIMEOUT_CYC))
      begin
         // Start then stop abandons everything, as any stop does
         next_state     = SGX_IDLE;
         next_sda_drive = 1'b0;
         next_have_reg  = 1'b0;
      end
      else
         case (state)
            SGX_IDLE:
            begin
            end
            SGX_ADDR, SGX_REG, SGX_WDATA:
               if (scl_rise)
               begin
                  next_shreg  = {shreg[6:0], sda_q};
                  next_bitcnt = bitcnt + 4'h1;
               end
               else if (scl_fall && bitcnt == 4'h8)
               begin
                  next_bitcnt = 4'h0;
                  if (state == SGX_ADDR)
                  begin
                     // Only own address acks; alert address never matches
                     if (shreg[7:1] == {`SGX_SLAVE_ADDR_HI, addr_sel_i}
                         && (!shreg[0] || have_reg))
                     begin
                        next_is_read   = shreg[0];
                        next_sda_drive = 1'b1;
                        next_state     = SGX_ADDR_ACK;
                     end
                     else
                        next_state = SGX_WAIT;
                  end
                  else if (state == SGX_REG)
                  begin
                     if (reg_valid(shreg))
                     begin
                        next_reg_addr  = shreg;
                        next_have_reg  = 1'b1;
                        next_sda_drive = 1'b1;
                        next_state     = SGX_REG_ACK;
                     end
                     else
                        next_state = SGX_WAIT;
                  end
                  else
                  begin
                     wr_stb         = 1'b1;
                     next_have_reg  = 1'b0;
                     next_sda_drive = 1'b1;
                     next_state     = SGX_WDATA_ACK;
                  end
               end
            SGX_ADDR_ACK:
               if (scl_fall)
               begin
                  if (is_read)
                  begin
                     // Status clear at the very start of the data read
                     rd_stb         = 1'b1;
                     next_shreg     = rd_data;
                     next_sda_drive = !rd_data[7];
                     next_state     = SGX_RDATA;
                  end
                  else
                  begin
                     next_sda_drive = 1'b0;
                     next_state     = SGX_REG;
                  end
               end
            SGX_REG_ACK:
               if (scl_fall)
               begin
                  next_sda_drive = 1'b0;
                  next_state     = SGX_WDATA;
               end
            SGX_WDATA_ACK:
               if (scl_fall)
               begin
                  next_sda_drive = 1'b0;
                  next_state     = SGX_WAIT;
               end
            SGX_RDATA:
               if (scl_fall)
               begin
                  next_bitcnt = bitcnt + 4'h1;
                  next_shreg  = {shreg[6:0], 1'b0};
                  if (bitcnt == 4'h7)
                  begin
                     next_sda_drive = 1'b0;
                     next_have_reg  = 1'b0;
                     next_state     = SGX_WAIT;
                  end
                  else
                     next_sda_drive = !shreg[6];
               end
            SGX_WAIT:
            begin
            end
            default:
               next_state = SGX_IDLE;
         endcase
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (rst_i)
      begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
         scl_d <= 1'b1;
         sda_d <= 1'b1;
         state       <= SGX_IDLE;
         bitcnt      <= 4'h0;
         shreg       <= 8'h00;
         reg_addr    <= 8'h00;
         is_read     <= 1'b0;
         have_reg    <= 1'b0;
         sda_drive   <= 1'b0;
         tmo         <= 32'h0;
      end
      else
      begin
         scl_q <= main_serial_clk_i;
         sda_q <= main_serial_data_i;
         scl_d <= scl_q;
         sda_d <= sda_q;
         state       <= next_state;
         bitcnt      <= next_bitcnt;
         shreg       <= next_shreg;
         reg_addr    <= next_reg_addr;
         is_read     <= next_is_read;
         have_reg    <= next_have_reg;
         sda_drive   <= next_sda_drive;
         tmo         <= next_tmo;
      end
   end

   // GPIO register and change logic
   always_comb
   begin
      next_iso       = iso_sel;
      next_iso_pend  = iso_pend;
      next_iso_apply = iso_apply;
      next_chg       = chg;
      next_warm      = (warm == 2'h3) ? warm : warm + 2'h1;
      for (int k = 0; k < NB; k++)
      begin
         next_dir[k]  = dir[k];
         next_type[k] = drv_type[k];
         next_out[k]  = out_level[k];
         next_mask[k] = evt_mask[k];
         // Output pins keep the last input value
         next_in[k]   = (dir[k] & in_level[k])
                        | (~dir[k] & sync2[k*8 +: 8]);
         if (rd_stb && reg_addr[7:2] == `SGX_OFF_DATA0 >> 2
             && reg_addr[1:0] == 2'(k))
            next_chg[k] = 1'b0;
         // No edges until the pin history holds real samples
         if (warm == 2'h3 && |(~dir[k] & ~evt_mask[k]
               & (sync2[k*8 +: 8] ^ pin_prev[k*8 +: 8])))
            next_chg[k] = 1'b1;
         // Isolation and status offsets overlap the mask decode
         if (wr_stb && reg_addr != `SGX_OFF_ISO && reg_addr != `SGX_OFF_CHG)
         begin
            if (reg_addr[7:2] == `SGX_OFF_DIR0 >> 2 && reg_addr[1:0] == 2'(k))
               next_dir[k] = shreg;
            if (reg_addr[7:2] == `SGX_OFF_TYPE0 >> 2
                && reg_addr[1:0] == 2'(k))
               next_type[k] = shreg;
            if (reg_addr[7:2] == `SGX_OFF_DATA0 >> 2
                && reg_addr[1:0] == 2'(k))
               next_out[k] = shreg;
            if (reg_addr[7:2] == `SGX_OFF_MASK0 >> 2
                && reg_addr[1:0] == 2'(k))
               next_mask[k] = shreg;
         end
      end
      if (wr_stb && reg_addr == `SGX_OFF_ISO)
      begin
         next_iso_pend  = shreg[`SGX_ISO_MSB:`SGX_ISO_LSB];
         next_iso_apply = 1'b1;
      end
      if (iso_apply && stop_det)
      begin
         next_iso       = iso_pend;
         next_iso_apply = 1'b0;
      end
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (rst_i)
      begin
         for (int k = 0; k < NB; k++)
         begin
            dir[k]       <= `SGX_RST_DIR;
            drv_type[k]  <= `SGX_RST_TYPE;
            out_level[k] <= `SGX_RST_DATA;
            evt_mask[k]  <= `SGX_RST_MASK;
            in_level[k]  <= 8'h00;
         end
         chg       <= '0;
         iso_sel   <= `SGX_RST_ISO;
         iso_pend  <= `SGX_RST_ISO;
         iso_apply <= 1'b0;
         sync1     <= '0;
         sync2     <= '0;
         pin_prev  <= '0;
         warm      <= 2'h0;
      end
      else
      begin
         for (int k = 0; k < NB; k++)
         begin
            dir[k]       <= next_dir[k];
            drv_type[k]  <= next_type[k];
            out_level[k] <= next_out[k];
            evt_mask[k]  <= next_mask[k];
            in_level[k]  <= next_in[k];
         end
         chg       <= next_chg;
         iso_sel   <= next_iso;
         iso_pend  <= next_iso_pend;
         iso_apply <= next_iso_apply;
         sync1     <= gpio_pins_i;
         sync2     <= sync1;
         pin_prev  <= sync2;
         warm      <= next_warm;
      end
   end

   // Pin drivers: bit set in direction means output, open-drain drives low
   genvar g;
   generate
      for (g = 0; g < NP; g++)
      begin : g_pin
         assign gpio_pins_o[g]    = out_level[g/8][g%8] & ~drv_type[g/8][g%8];
         assign gpio_pins_oe_o[g] = dir[g/8][g%8]
                                    & (~drv_type[g/8][g%8]
                                       | ~out_level[g/8][g%8]);
      end
   endgenerate

   // Isolation switch: a low seen on one joined bus is driven onto others
   always_comb
   begin
      main_serial_clk_oe_o  = (iso_sel[0] && !branch1_clk_i)
                              || (iso_sel[1] && !branch2_clk_i);
      main_serial_data_oe_o = sda_drive
                              || (iso_sel[0] && !branch1_data_i)
                              || (iso_sel[1] && !branch2_data_i);
      branch1_clk_oe_o  = iso_sel[0] && (!main_serial_clk_i
                          || (iso_sel[1] && !branch2_clk_i));
      branch1_data_oe_o = iso_sel[0] && (!main_serial_data_i || sda_drive
                          || (iso_sel[1] && !branch2_data_i));
      branch2_clk_oe_o  = iso_sel[1] && (!main_serial_clk_i
                          || (iso_sel[0] && !branch1_clk_i));
      branch2_data_oe_o = iso_sel[1] && (!main_serial_data_i || sda_drive
                          || (iso_sel[0] && !branch1_data_i));
   end

   assign gpio_change_irq_n_o    = 1'b0;
   assign gpio_change_irq_n_oe_o = |chg;
endmodule : sgx_expander
`default_nettype wire

// ==== sim/sgx_expander_chk.sv ====
// Port-level assertion checker for the GPIO expander
`timescale 1ns/1ps
`default_nettype none
module sgx_expander_chk #(
   parameter int NUM_BANKS = 4
)(
   input wire logic                   ref_clk_i,
   input wire logic                   rst_i,
   input wire logic                   main_serial_clk_i,
   input wire logic                   main_serial_clk_oe_o,
   input wire logic                   main_serial_data_i,
   input wire logic                   branch1_clk_i,
   input wire logic                   branch1_clk_oe_o,
   input wire logic                   branch1_data_i,
   input wire logic                   branch2_clk_i,
   input wire logic                   branch2_clk_oe_o,
   input wire logic                   branch2_data_oe_o,
   input wire logic [NUM_BANKS*8-1:0] gpio_pins_i,
   input wire logic [NUM_BANKS*8-1:0] gpio_pins_o,
   input wire logic [NUM_BANKS*8-1:0] gpio_pins_oe_o,
   input wire logic                   gpio_change_irq_n_oe_o
);
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (rst_i);

   property p_no_stretch;
      main_serial_clk_oe_o |-> !branch1_clk_i || !branch2_clk_i;
   endproperty
   a_no_stretch: assert property (p_no_stretch)
      else $error("main clock pulled low by the block itself");
   property p_iso_reset;
      $fell(rst_i) |-> !branch1_clk_oe_o && !branch2_clk_oe_o
                       && !branch2_data_oe_o;
   endproperty
   a_iso_reset: assert property (p_iso_reset)
      else $error("branch driven right after reset");
   property p_pins_reset;
      $fell(rst_i) |-> (gpio_pins_oe_o == '0 && !gpio_change_irq_n_oe_o)[*4];
   endproperty
   a_pins_reset: assert property (p_pins_reset)
      else $error("pin driven or interrupt active after reset");
   property p_irq_cause;
      $rose(gpio_change_irq_n_oe_o) |->
         $past(gpio_pins_i, 1) != $past(gpio_pins_i, 8);
   endproperty
   a_irq_cause: assert property (p_irq_cause)
      else $error("interrupt raised without a pin change");
   property p_b1_join;
      branch1_clk_oe_o |-> !main_serial_clk_i || !branch2_clk_i;
   endproperty
   a_b1_join: assert property (p_b1_join)
      else $error("branch one clock pulled with no low source");
   property p_b2_join;
      branch2_data_oe_o |-> !main_serial_data_i || !branch1_data_i;
   endproperty
   a_b2_join: assert property (p_b2_join)
      else $error("branch two data pulled with no low source");
   property p_cfg_scl;
      $changed(gpio_pins_oe_o) || $changed(gpio_pins_o) |->
         !main_serial_clk_i;
   endproperty
   a_cfg_scl: assert property (p_cfg_scl)
      else $error("pin outputs changed outside a bus write");
   property p_irq_clear;
      $fell(gpio_change_irq_n_oe_o) |-> !main_serial_clk_i;
   endproperty
   a_irq_clear: assert property (p_irq_clear)
      else $error("interrupt cleared outside a bus read");

   c_irq: cover property ($rose(gpio_change_irq_n_oe_o));
   c_join: cover property (branch2_clk_oe_o && !branch1_clk_i);
   c_out: cover property ($rose(|gpio_pins_oe_o));
endmodule : sgx_expander_chk
bind sgx_expander sgx_expander_chk #(.NUM_BANKS(NUM_BANKS)) sgx_expander_chk_i (
   .ref_clk_i, .rst_i, .main_serial_clk_i, .main_serial_clk_oe_o,
   .main_serial_data_i, .branch1_clk_i, .branch1_clk_oe_o, .branch1_data_i,
   .branch2_clk_i, .branch2_clk_oe_o, .branch2_data_oe_o, .gpio_pins_i,
   .gpio_pins_o, .gpio_pins_oe_o, .gpio_change_irq_n_oe_o);
`default_nettype wire

// ==== sim/sgx_host.sv ====
// Behavioural SMBus host on the main clock and data wires
`timescale 1ns/1ps
`default_nettype none
module sgx_host #(
   parameter int HALF = 8
)(
   input  wire logic ref_clk_i,
   input  wire logic scl_i,
   input  wire logic sda_i,
   output logic      scl_low_o,
   output logic      sda_low_o
);
   int stretch;
   initial
   begin
      stretch = 0;
      scl_low_o = 1'b0;
      sda_low_o = 1'b0;
   end
   task automatic hold(input int n);
      repeat (n) @(posedge ref_clk_i);
      #1;
   endtask : hold
   task automatic start_c();
      sda_low_o = 1'b0;
      hold(HALF);
      scl_low_o = 1'b0;
      hold(HALF);
      sda_low_o = 1'b1;
      hold(HALF);
      scl_low_o = 1'b1;
      hold(HALF);
   endtask : start_c
   task automatic stop_c();
      sda_low_o = 1'b1;
      hold(HALF);
      scl_low_o = 1'b0;
      hold(HALF);
      sda_low_o = 1'b0;
      hold(HALF);
   endtask : stop_c
   task automatic bit_c(input logic b, output logic r);
      sda_low_o = !b;
      hold(HALF + stretch);
      scl_low_o = 1'b0;
      for (int k = 0; k < 64 && !scl_i; k++)
         hold(1);
      hold(HALF);
      r = sda_i;
      scl_low_o = 1'b1;
      hold(4);
   endtask : bit_c
   task automatic byte_c(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--)
         bit_c(d[i], r);
      bit_c(1'b1, r);
      ack = !r;
   endtask : byte_c
   task automatic write_reg(input logic [6:0] a, input logic [7:0] rg, dt,
                            output logic ok);
      logic a0, a1, a2;
      start_c();
      byte_c({a, 1'b0}, a0);
      byte_c(rg, a1);
      byte_c(dt, a2);
      stop_c();
      ok = a0 & a1 & a2;
   endtask : write_reg
   task automatic read_reg(input logic [6:0] a, input logic [7:0] rg,
                           output logic [7:0] d, output logic ok);
      logic a0, a1, a2, r;
      start_c();
      byte_c({a, 1'b0}, a0);
      byte_c(rg, a1);
      start_c();
      byte_c({a, 1'b1}, a2);
      for (int i = 7; i >= 0; i--)
         bit_c(1'b1, d[i]);
      bit_c(1'b1, r);
      stop_c();
      ok = a0 & a1 & a2;
   endtask : read_reg
endmodule : sgx_host
`default_nettype wire

// ==== sim/sgx_expander_tb.sv ====
// Self-checking testbench for the GPIO expander
`timescale 1ns/1ps
`default_nettype none
module sgx_expander_tb;
   localparam logic [6:0] ME = 7'h25;
   logic        ref_clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic [1:0]  b1_low = 2'h0;
   logic [1:0]  b2_low = 2'h0;
   logic [31:0] pin_ext = 32'h0;
   wire  logic  m_scl, m_sda, h_scl, h_sda, m_scl_oe, m_sda_oe;
   wire  logic  b1c_oe, b1d_oe, b2c_oe, b2d_oe, irq_oe, irq_n;
   wire  logic [31:0] pins_i, pins_o, pins_oe;
   int          mismatches = 0;
   int          checks_done = 0;
   int          cycles = 0;

   assign m_scl = !(h_scl | m_scl_oe);
   assign m_sda = !(h_sda | m_sda_oe);
   assign pins_i = (pins_oe & pins_o) | (~pins_oe & pin_ext);

   sgx_expander #(.TIMEOUT_CYC(2000)) sgx_expander_i (
      .ref_clk_i, .rst_i, .addr_sel_i(1'b1),
      .main_serial_clk_i(m_scl), .main_serial_clk_oe_o(m_scl_oe),
      .main_serial_data_i(m_sda), .main_serial_data_oe_o(m_sda_oe),
      .branch1_clk_i(!b1_low[0]), .branch1_clk_oe_o(b1c_oe),
      .branch1_data_i(!b1_low[1]), .branch1_data_oe_o(b1d_oe),
      .branch2_clk_i(!b2_low[0]), .branch2_clk_oe_o(b2c_oe),
      .branch2_data_i(!b2_low[1]), .branch2_data_oe_o(b2d_oe),
      .gpio_pins_i(pins_i), .gpio_pins_o(pins_o), .gpio_pins_oe_o(pins_oe),
      .gpio_change_irq_n_o(irq_n), .gpio_change_irq_n_oe_o(irq_oe));
   sgx_host sgx_host_i (.ref_clk_i, .scl_i(m_scl), .sda_i(m_sda),
      .scl_low_o(h_scl), .sda_low_o(h_sda));

   always #2 ref_clk_i = ~ref_clk_i;
   always @(posedge ref_clk_i)
   begin
      cycles++;
      if (cycles == 90000)
      begin
         mismatches++;
         print_verdict();
      end
   end

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : print_verdict
   task automatic check(input logic [31:0] seen, exp);
      checks_done++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic settle();
      repeat (8) @(posedge ref_clk_i);
      #1;
   endtask : settle
   task automatic wr(input logic [7:0] rg, dt);
      logic ok;
      sgx_host_i.write_reg(ME, rg, dt, ok);
      check(ok, 1'b1);
   endtask : wr
   task automatic rdc(input logic [7:0] rg, exp);
      logic [7:0] d;
      logic       ok;
      sgx_host_i.read_reg(ME, rg, d, ok);
      check({ok, d}, {1'b1, exp});
   endtask : rdc

   task automatic t_reset();
      for (int r = 0; r < 16; r++)
         rdc(8'(r), 8'h00);
      check(pins_oe, 32'h0);
      check(irq_oe, 1'b0);
   endtask : t_reset
   task automatic t_refuse();
      logic [7:0] d;
      logic       ok;
      sgx_host_i.read_reg(ME, 8'h10, d, ok);
      check(ok, 1'b0);
      sgx_host_i.read_reg(7'h0C, 8'h00, d, ok);
      check(ok, 1'b0);
   endtask : t_refuse
   task automatic t_bus_reset();
      logic r;
      sgx_host_i.start_c();
      sgx_host_i.byte_c({ME, 1'b0}, r);
      sgx_host_i.bit_c(1'b0, r);
      sgx_host_i.start_c();
      sgx_host_i.stop_c();
      wr(8'h07, 8'h3C);
      rdc(8'h07, 8'h3C);
   endtask : t_bus_reset
   task automatic t_iso();
      logic [1:0] s;
      logic [1:0] got;
      for (int k = 0; k < 4; k++)
      begin
         s = 2'(k);
         wr(8'h0E, {6'h00, s});
         rdc(8'h0E, {6'h00, s});
         for (int j = 0; j < 2; j++)
         begin
            b1_low = 2'(1 << j);
            settle();
            got = j ? {m_sda_oe, b2d_oe} : {m_scl_oe, b2c_oe};
            check(got, {s[0], &s});
            b1_low = 2'h0;
            b2_low = 2'(1 << j);
            settle();
            got = j ? {m_sda_oe, b1d_oe} : {m_scl_oe, b1c_oe};
            check(got, {s[1], &s});
            b2_low = 2'h0;
            settle();
         end
      end
      wr(8'h0E, 8'hFC);
      rdc(8'h0E, 8'h00);
   endtask : t_iso
   task automatic t_outputs();
      wr(8'h08, 8'hA5);
      rdc(8'h0F, 8'h00);
      wr(8'h00, 8'hFF);
      check({pins_o[7:0], pins_oe[7:0]}, 16'hA5FF);
      wr(8'h04, 8'hFF);
      check(pins_oe[7:0], 8'h5A);
      rdc(8'h08, 8'hA5);
      pin_ext[0] = 1'b1;
      settle();
      check(irq_oe, 1'b0);
      rdc(8'h0F, 8'h00);
   endtask : t_outputs
   task automatic t_change();
      pin_ext[16] = 1'b1;
      settle();
      check(irq_oe, 1'b1);
      check(irq_n, 1'b0);
      pin_ext[31] = 1'b1;
      settle();
      rdc(8'h0F, 8'h0C);
      rdc(8'h0A, 8'h01);
      check(irq_oe, 1'b1);
      rdc(8'h0F, 8'h08);
      rdc(8'h0B, 8'h80);
      check(irq_oe, 1'b0);
      pin_ext[16] = 1'b0;
      settle();
      rdc(8'h0F, 8'h04);
      fork
         rdc(8'h0A, 8'h00);
         begin
            repeat (700) @(posedge ref_clk_i);
            #1 pin_ext[23] = 1'b1;
         end
      join
      rdc(8'h0F, 8'h04);
      rdc(8'h0A, 8'h80);
      check(irq_oe, 1'b0);
   endtask : t_change
   task automatic t_mask();
      wr(8'h0D, 8'h01);
      pin_ext[8] = 1'b1;
      settle();
      check(irq_oe, 1'b0);
      pin_ext[9] = 1'b1;
      settle();
      rdc(8'h0F, 8'h02);
      rdc(8'h09, 8'h03);
      check(irq_oe, 1'b0);
   endtask : t_mask
   task automatic t_stretch();
      sgx_host_i.stretch = 200;
      wr(8'h03, 8'h5A);
      rdc(8'h03, 8'h5A);
      sgx_host_i.stretch = 0;
   endtask : t_stretch

   initial
   begin
      repeat (20) @(posedge ref_clk_i);
      #1 rst_i = 1'b0;
      repeat (2) @(posedge ref_clk_i);
      #1;
      t_reset();
      t_refuse();
      t_bus_reset();
      t_iso();
      t_outputs();
      t_change();
      t_mask();
      t_stretch();
      print_verdict();
   end
endmodule : sgx_expander_tb
`default_nettype wire
